// file: qsa_pkg.sv
package qsa_pkg;
  localparam int unsigned NUM_LANES    = 4;
  localparam logic        SUM_CLR_VAL  = 1'b0;
  localparam logic        CARRY_CLR    = 1'b0;
  localparam logic        PEND_CLR_VAL = 1'b1;
  localparam logic        MODE_ADD     = 1'b0;
  localparam logic        MODE_SUB     = 1'b1;
endpackage

// file: qsa_quad_serial_add_subtract.sv
// Operation
// [RULE1] four lanes, shared clock and clear
// [RULE2] each lane: result flop and carry flop
// [RULE3] state changes only on rising clock edge; code also loads the sum, carry and pend flops when async_clear_n falls
// [RULE4] mode low adds, mode high subtracts
// [RULE5] clear zeroes result, carry follows mode; code takes the preset from the mode at the last rising edge under clear
// [RULE6] clear acts asynchronously, overrides all lanes
// [RULE7] subtract inverts second operand internally
// [RULE8] preset carry added in first bit operation
// [RULE9] operands arrive lsb first after clear
// [RULE10] ones-complement: mode raised after clear release
// [RULE11] each lane drives registered result bit
// [RULE12] sum is xor, carry is majority
module qsa_quad_serial_add_subtract
  import qsa_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 async_clear_n,
  input  wire logic [NUM_LANES-1:0] operand_a,
  input  wire logic [NUM_LANES-1:0] operand_b,
  input  wire logic [NUM_LANES-1:0] mode_sub,
  output logic      [NUM_LANES-1:0] result_bit
);

  // sum and carry out of one bit step travel together
  typedef struct packed {
    logic sum;
    logic carry;
  } qsa_step_s;

  function automatic logic sum3
  (
    input logic x,
    input logic y,
    input logic z
  );
  begin
    sum3 = x ^ y ^ z; // [RULE12]
  end
  endfunction

  function automatic logic maj3
  (
    input logic x,
    input logic y,
    input logic z
  );
  begin
    maj3 = (x & y) | (x & z) | (y & z); // [RULE12]
  end
  endfunction

  function automatic logic is_sub
  (
    input logic mode
  );
  begin
    is_sub = (mode == MODE_SUB); // [RULE4]
  end
  endfunction

  // b follows the live mode, not the one captured under clear
  function automatic logic eff_operand
  (
    input logic b,
    input logic mode
  );
  begin
    eff_operand = b ^ is_sub(mode); // [RULE7]
  end
  endfunction

  function automatic qsa_step_s add_step
  (
    input logic a,
    input logic b,
    input logic c
  );
    qsa_step_s step_v;
  begin
    step_v.sum   = sum3(a, b, c);
    step_v.carry = maj3(a, b, c);
    add_step     = step_v;
  end
  endfunction

  // what either clear leaves in a lane
  function automatic qsa_step_s cleared_step();
  begin
    cleared_step.sum   = SUM_CLR_VAL; // [RULE5]
    cleared_step.carry = CARRY_CLR;
  end
  endfunction

  // sync reset acts like the clear but only at a rising edge
  function automatic qsa_step_s sync_reset
  (
    input qsa_step_s step_in,
    input logic      rst_low
  );
  begin
    sync_reset = rst_low ? cleared_step() : step_in;
  end
  endfunction

  // mode kept while the clear is held, old value otherwise
  function automatic logic capture_mode
  (
    input logic held,
    input logic clear_low,
    input logic live
  );
  begin
    capture_mode = clear_low ? live : held;
  end
  endfunction

  // the first bit after a clear takes the preset, later bits the saved
  // carry; the carry flop itself only ever clears to a constant
  function automatic logic pick_carry
  (
    input logic pend,
    input logic cap_mode,
    input logic carry
  );
  begin
    pick_carry = pend ? is_sub(cap_mode) : carry; // [RULE8]
  end
  endfunction

  genvar lane;

  // lanes share clk, rst_n and the clear; nothing else crosses over
  generate
    for (lane = 0; lane < NUM_LANES; lane++) // [RULE1]
    begin : g_lane
      // stored state of the lane
      logic      sum_reg;
      logic      sum_next;
      logic      carry_reg;
      logic      carry_next;
      logic      pend_reg;
      logic      pend_next;
      logic      cap_mode_reg;
      logic      cap_mode_next;

      // bit step datapath
      logic      b_eff;
      logic      carry_eff;
      qsa_step_s step;

      // mode seen at the last edge under clear; a clear that misses
      // every rising edge leaves the older mode in place
      always_comb
      begin
        cap_mode_next = capture_mode(cap_mode_reg, !async_clear_n,
                                     mode_sub[lane]); // [RULE5]
      end

      always_ff @(posedge clk)
      begin
        cap_mode_reg <= cap_mode_next;
      end

      // preset pending: set by either clear, gone after one bit step
      always_comb
      begin
        pend_next = !PEND_CLR_VAL; // [RULE8]
        if (!rst_n)
        begin
          pend_next = PEND_CLR_VAL;
        end
      end

      always_ff @(posedge clk or negedge async_clear_n) // [RULE6]
      begin
        if (!async_clear_n)
        begin
          pend_reg <= PEND_CLR_VAL;
        end
        else
        begin
          pend_reg <= pend_next;
        end
      end

      // effective operand and carry for this edge
      always_comb
      begin
        b_eff = eff_operand(operand_b[lane], mode_sub[lane]); // [RULE7]
        carry_eff = pick_carry(pend_reg, cap_mode_reg, carry_reg);
      end

      // add step, then the sync reset override
      always_comb
      begin
        step       = add_step(operand_a[lane], b_eff, carry_eff); // [RULE12]
        step       = sync_reset(step, !rst_n);
        sum_next   = step.sum;
        carry_next = step.carry;
      end

      // async branch loads constants only, so no mode reaches it
      always_ff @(posedge clk or negedge async_clear_n) // [RULE3] [RULE6]
      begin
        if (!async_clear_n)
        begin
          sum_reg   <= SUM_CLR_VAL; // [RULE5]
          carry_reg <= CARRY_CLR;
        end
        else
        begin
          sum_reg   <= sum_next; // [RULE2]
          carry_reg <= carry_next; // [RULE2]
        end
      end

      // result flop drives the pin directly; no extra stage
      assign result_bit[lane] = sum_reg; // [RULE11]
    end
  endgenerate

endmodule

// file: qsa_chk.sv
module qsa_chk
  import qsa_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 async_clear_n,
  input wire logic [NUM_LANES-1:0] operand_a,
  input wire logic [NUM_LANES-1:0] operand_b,
  input wire logic [NUM_LANES-1:0] mode_sub,
  input wire logic [NUM_LANES-1:0] result_bit
);
  logic [NUM_LANES-1:0] ref_mode;
  logic [NUM_LANES-1:0] ref_carry;
  logic [NUM_LANES-1:0] ref_b;

  // reference carry built from the rules, one bit step per edge
  assign ref_b = operand_b ^ mode_sub;
  always_ff @(posedge clk)
  begin
    if (!async_clear_n)
      ref_mode <= mode_sub;
    if (!async_clear_n)
      ref_carry <= mode_sub;
    else if (!rst_n)
      ref_carry <= ref_mode;
    else
      ref_carry <= (operand_a & ref_b) | (operand_a & ref_carry)
                   | (ref_b & ref_carry);
  end

  a_clr_zero: assert property (@(posedge clk)
    !async_clear_n |=> result_bit == '0) else $error("clear not zero");
  a_rst_zero: assert property (@(posedge clk)
    !rst_n |=> result_bit == '0) else $error("reset not zero");
  a_first_bit: assert property (@(posedge clk)
    rst_n && $rose(async_clear_n) |=> !async_clear_n ||
    result_bit == ($past(operand_a ^ operand_b ^ mode_sub) ^
    $past(mode_sub, 2))) else $error("first bit wrong");
  a_sub_first: assert property (@(posedge clk)
    rst_n && $rose(async_clear_n) |=> !async_clear_n ||
    ((result_bit ^ $past(operand_a ^ operand_b)) & $past(mode_sub) &
    $past(mode_sub, 2)) == '0) else $error("sub preset not added");
  a_sum_xor: assert property (@(posedge clk)
    async_clear_n && rst_n |=> !async_clear_n ||
    result_bit == $past(operand_a ^ ref_b ^ ref_carry))
    else $error("sum bit wrong");
  a_rst_carry: assert property (@(posedge clk)
    (async_clear_n && !rst_n) ##1 (async_clear_n && rst_n) |=>
    !async_clear_n || result_bit == $past(operand_a ^ ref_b ^ ref_mode))
    else $error("reset preset wrong");
endmodule
bind qsa_quad_serial_add_subtract qsa_chk chk_u (.*);

// file: qsa_src.sv
module qsa_src
  import qsa_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 load,
  input  wire logic [7:0]           wa,
  input  wire logic [7:0]           wb,
  output logic      [NUM_LANES-1:0] operand_a,
  output logic      [NUM_LANES-1:0] operand_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sa = '0;
  logic [7:0] sb = '0;
  // lsb first, one pair a clock
  always @(negedge clk)
  begin
    sa <= load ? wa : sa >> 1;
    sb <= load ? wb : sb >> 1;
  end
  assign operand_a = {NUM_LANES{sa[0]}};
  assign operand_b = {NUM_LANES{sb[0]}};
endmodule

// file: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qsa_pkg::*;
  `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic       clk = 0, rst_n = 0, clr_n = 0;
  logic [3:0] mode = 0, opa, opb, res;
  logic [7:0] wa = 0, wb = 0, got [4];
  int         err_count = 0, n_checks = 0;
  always #4 clk = ~clk;
  qsa_src src_u (.clk(clk), .load(!clr_n || !rst_n), .wa(wa), .wb(wb),
    .operand_a(opa), .operand_b(opb));
  qsa_quad_serial_add_subtract dut_u (.clk(clk), .rst_n(rst_n),
    .async_clear_n(clr_n), .operand_a(opa), .operand_b(opb),
    .mode_sub(mode), .result_bit(res));
  // mc: mode captured by the clear; a sync reset (use_rst) keeps the mode
  // of the last clear, so mc must match it and the live mode is flipped
  task run(input bit use_rst, input logic [3:0] mc, mr,
    input logic [7:0] a, b);
    @(negedge clk);
    if (use_rst)
    begin
      rst_n <= 0;
      mode  <= ~mc;
    end
    else
    begin
      clr_n <= 0;
      mode  <= mc;
    end
    wa <= a;
    wb <= b;
    @(negedge clk);
    `CHK("clear", 4'h0, res)
    clr_n <= 1;
    rst_n <= 1;
    mode  <= mr;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      for (int l = 0; l < 4; l++)
        got[l][i] = res[l];
    end
    for (int l = 0; l < 4; l++)
      `CHK("lane", 8'(a + (mr[l] ? ~b : b) + mc[l]), got[l])
  endtask
  task scn_mixed;
    run(1'h0, 4'ha, 4'ha, 8'h5c, 8'h3b);
  endtask
  task scn_sub;
    run(1'h0, 4'hf, 4'hf, 8'h17, 8'h29);
  endtask
  task scn_ones;
    run(1'h0, 4'h0, 4'hf, 8'h17, 8'h29);
  endtask
  task scn_add;
    run(1'h0, 4'h0, 4'h0, 8'hff, 8'h01);
  endtask
  task scn_sync_rst;
    run(1'h0, 4'h5, 4'h5, 8'h6e, 8'h91);
    run(1'h1, 4'h5, 4'h5, 8'h33, 8'hc4);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n <= 1;
    scn_mixed;
    scn_sub;
    scn_ones;
    scn_add;
    scn_sync_rst;
    results;
  end
endmodule
